// [src/isa_diff_decoder.sv]
// Decode/retire stage for instructions whose behaviour departs from the base ISA
`timescale 1ns/10ps
`default_nettype none
module isa_diff_decoder
  import isa_diff_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_b_i,
  input  wire logic                      instr_valid_i,
  input  wire isa_diff_pkg::instr_s      instr_i,
  input  wire logic                      sys_coproc_usable_bit_i,
  input  wire logic [isa_diff_pkg::WAY_W-1:0] vaddr_lo_i,
  input  wire logic                      mem_idle_i,
  output logic                           instr_ready_o,
  output isa_diff_pkg::result_s          result_o,
  output logic                           mem_hold_o
);
  import isa_diff_pkg::*;

  typedef enum logic {ST_RUN, ST_BARRIER} state_e;

  state_e     state_q;
  state_e     state_d;
  logic       accept;
  instr_kind_e kind;
  cache_tgt_e c_tgt;
  cache_act_e c_act;
  logic       sync_ok;
  logic       sync_bad_type;
  logic       sync_no_cu;
  result_s    result_d;

  // Classify one instruction word by its encoding
  function automatic instr_kind_e classify(input instr_s w);
    instr_kind_e k;
    k = K_OTHER;
    case (w.opc)
      OPC_PREFETCH_OP:
        k = K_NOP;
      OPC_COP1X:
        if (w.fn == FN_PREFETCH_INDEXED_OP)
          k = K_NOP;
      OPC_SPECIAL:
        if (w.fn == FN_SYNC)
          k = K_SYNC;
        else if (w.fn == FN_SLL && w.rs == REG_ZERO && w.rt == REG_ZERO &&
                 w.rd == REG_ZERO && (w.sa == SA_SINGLE_ISSUE_NOOP || w.sa == SA_EHB))
          k = K_NOP;
      OPC_COP0:
        if (w.rs[RS_CO_BIT] && w.fn == FN_WAIT)
          k = K_WAIT;
        else if (w.rs == RS_RDSHADOW)
          k = K_SHADOW_RD;
        else if (w.rs == RS_WRSHADOW)
          k = K_SHADOW_WR;
        else if (w.rs == RS_MFMC0)
          k = K_IRQ_CTL;
      OPC_CACHE:
        k = K_CACHE;
      default:
        k = K_OTHER;
    endcase
    return k;
  endfunction : classify

  cache_op_decode u_cache_op_decode (
    .cache_op_field_i (instr_i.rt),
    .tgt_o            (c_tgt),
    .act_o            (c_act)
  );

  // Handshake and barrier qualifiers
  assign accept        = instr_valid_i && instr_ready_o;
  assign kind          = classify(instr_i);
  assign sync_bad_type = (kind == K_SYNC) && (instr_i.sa != SYNC_TYPE0);
  assign sync_no_cu    = (kind == K_SYNC) && !sync_bad_type &&
                         !sys_coproc_usable_bit_i;
  assign sync_ok       = (kind == K_SYNC) && !sync_bad_type && sys_coproc_usable_bit_i;

  // Barrier sequencing: a good barrier parks the stage until memory drains
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
        if (accept && sync_ok)
          state_d = ST_BARRIER;
      ST_BARRIER:
        if (mem_idle_i)
          state_d = ST_RUN;
      default:
        state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state_q <= ST_RUN;
    else
      state_q <= state_d;
  end

  // Ready drops for the whole barrier so no later access can issue
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      instr_ready_o <= 1'b0;
      mem_hold_o    <= 1'b0;
    end
    else
    begin
      instr_ready_o <= (state_d == ST_RUN);
      mem_hold_o    <= (state_d == ST_BARRIER);
    end
  end

  // Result word for the instruction taken this cycle
  always_comb
  begin
    result_d          = '0;
    result_d.kind     = kind;
    result_d.cache.tgt = TGT_NONE;
    result_d.cache.act = ACT_NONE;
    if (state_q == ST_BARRIER)
    begin
      // Barrier retires only once every earlier access has completed
      result_d.valid = mem_idle_i;
      result_d.kind  = K_SYNC;
    end
    else if (accept)
    begin
      result_d.valid = !sync_ok;
      case (kind)
        K_NOP, K_WAIT:
          result_d.kind = kind;
        K_SHADOW_RD, K_SHADOW_WR:
        begin
          // No shadow sets: both ends name the current register set
          result_d.move.valid = 1'b1;
          result_d.move.src   = instr_i.rt;
          result_d.move.dst   = instr_i.rd;
        end
        K_SYNC:
        begin
          result_d.exc_ri  = sync_bad_type;
          result_d.exc_cpu = sync_no_cu;
        end
        K_CACHE:
        begin
          // Unlisted codes leave cache state untouched
          result_d.cache.valid = (c_act != ACT_NONE);
          result_d.cache.tgt   = c_tgt;
          result_d.cache.act   = c_act;
          result_d.cache.way   = vaddr_lo_i;
        end
        K_IRQ_CTL:
          result_d.exc_ri = 1'b1;
        default:
          result_d.kind = K_OTHER;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      result_o           <= '0;
      result_o.cache.tgt <= TGT_NONE;
      result_o.cache.act <= ACT_NONE;
    end
    else
      result_o <= result_d;
  end

  // Checks on the retire stage
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_PREFETCH_OP_NOP: assert property (
    accept && (instr_i.opc == OPC_PREFETCH_OP ||
               (instr_i.opc == OPC_COP1X && instr_i.fn == FN_PREFETCH_INDEXED_OP))
    |=> result_o.valid && result_o.kind == K_NOP && !result_o.exc_ri &&
        !result_o.cache.valid && !mem_hold_o)
    else $error("prefetch did not retire as a no-op");

  AST_HAZ_NOP: assert property (
    accept && classify(instr_i) == K_NOP && instr_i.opc == OPC_SPECIAL
    |=> result_o.valid && result_o.kind == K_NOP && instr_ready_o)
    else $error("hazard no-op stalled or changed state");

  AST_WAIT_NO_STALL: assert property (
    accept && kind == K_WAIT |=> instr_ready_o && !mem_hold_o && result_o.valid)
    else $error("wait stalled the stage");

  AST_SHADOW_CURRENT: assert property (
    accept && (kind == K_SHADOW_RD || kind == K_SHADOW_WR)
    |=> result_o.move.valid && result_o.move.src == $past(instr_i.rt) &&
        result_o.move.dst == $past(instr_i.rd))
    else $error("shadow move did not use the current set");

  AST_SYNC_TYPE_RI: assert property (
    accept && sync_bad_type |=> result_o.exc_ri && !mem_hold_o && instr_ready_o)
    else $error("barrier of nonzero type not refused");

  AST_SYNC_HOLD: assert property (
    mem_hold_o && !mem_idle_i |=> mem_hold_o && !instr_ready_o && !result_o.valid)
    else $error("barrier released before memory drained");

  AST_SYNC_RELEASE: assert property (
    accept && sync_ok ##1 mem_idle_i
    |=> instr_ready_o && !mem_hold_o && result_o.valid && result_o.kind == K_SYNC)
    else $error("barrier did not release after memory drained");

  AST_SYNC_CPU: assert property (
    accept && sync_no_cu |=> result_o.exc_cpu && !result_o.exc_ri && !mem_hold_o)
    else $error("barrier without usability not refused");

  AST_WAY_LOW: assert property (
    accept && kind == K_CACHE && c_act != ACT_NONE
    |=> result_o.cache.valid && result_o.cache.way == $past(vaddr_lo_i))
    else $error("cache way not taken from low address bits");

  AST_STORE_DATA: assert property (
    accept && kind == K_CACHE && instr_i.rt[4:2] == CO_STORE_TOP && c_tgt != TGT_NONE
    |=> result_o.cache.act == ACT_IDX_DAT_WR)
    else $error("top-ones cache code not index store-data");

  AST_DHIT_INV: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_D_HIT_INV
    |=> result_o.cache.tgt == TGT_D && result_o.cache.act == ACT_HIT_INV)
    else $error("data hit invalidate misdecoded");

  AST_UNSUP_CACHE: assert property (
    accept && kind == K_CACHE && c_act == ACT_NONE
    |=> result_o.valid && !result_o.cache.valid)
    else $error("unsupported cache code changed state");

  AST_IRQ_RI: assert property (
    accept && kind == K_IRQ_CTL |=> result_o.exc_ri && result_o.kind == K_IRQ_CTL)
    else $error("interrupt control not refused");

  AST_IRQ_NO_EXEC: assert property (
    accept && kind == K_IRQ_CTL
    |=> !result_o.move.valid && !result_o.cache.valid && !result_o.exc_cpu && !mem_hold_o)
    else $error("interrupt control had a side effect");

  AST_SHADOW_NO_EXC: assert property (
    accept && (kind == K_SHADOW_RD || kind == K_SHADOW_WR)
    |=> result_o.valid && !result_o.exc_ri && !result_o.exc_cpu && !result_o.cache.valid)
    else $error("shadow move raised an exception");

  AST_OTHER_PLAIN: assert property (
    accept && kind == K_OTHER
    |=> result_o.valid && !result_o.exc_ri && !result_o.cache.valid && !result_o.move.valid)
    else $error("ordinary instruction got a side action");

  // Barrier bookkeeping: hold and ready never overlap, drain ends the hold
  AST_HOLD_READY: assert property (
    mem_hold_o |-> !instr_ready_o)
    else $error("stage ready while barrier holds memory");

  AST_SYNC_RETIRE: assert property (
    mem_hold_o && mem_idle_i |=> result_o.valid && result_o.kind == K_SYNC && !mem_hold_o)
    else $error("drained barrier did not retire");

  AST_TYPE_BEATS_CU: assert property (
    accept && sync_bad_type && !sys_coproc_usable_bit_i |=> result_o.exc_ri && !result_o.exc_cpu)
    else $error("type check did not win over usability");

  // Per-code cache checks, spelled out apart from the decode table
  AST_I_IDX_INV: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_I_IDX_INV
    |=> result_o.cache.tgt == TGT_I && result_o.cache.act == ACT_IDX_INV)
    else $error("icache index invalidate misdecoded");

  AST_I_IDX_TAG_WR: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_I_IDX_TAG_WR
    |=> result_o.cache.tgt == TGT_I && result_o.cache.act == ACT_IDX_TAG_WR)
    else $error("icache index tag write misdecoded");

  AST_I_IDX_DAT_WR: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_I_IDX_DAT_WR
    |=> result_o.cache.tgt == TGT_I && result_o.cache.act == ACT_IDX_DAT_WR)
    else $error("icache index data write misdecoded");

  AST_D_IDX_WBINV: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_D_IDX_WBINV
    |=> result_o.cache.tgt == TGT_D && result_o.cache.act == ACT_IDX_WB_INV)
    else $error("data index writeback invalidate misdecoded");

  AST_D_IDX_TAG_RD: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_D_IDX_TAG_RD
    |=> result_o.cache.tgt == TGT_D && result_o.cache.act == ACT_IDX_TAG_RD)
    else $error("data index tag read misdecoded");

  AST_D_IDX_TAG_WR: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_D_IDX_TAG_WR
    |=> result_o.cache.tgt == TGT_D && result_o.cache.act == ACT_IDX_TAG_WR)
    else $error("data index tag write misdecoded");

  AST_D_HIT_WBINV: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_D_HIT_WBINV
    |=> result_o.cache.tgt == TGT_D && result_o.cache.act == ACT_HIT_WB_INV)
    else $error("data hit writeback invalidate misdecoded");

  AST_D_IDX_DAT_RD: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_D_IDX_DAT_RD
    |=> result_o.cache.tgt == TGT_D && result_o.cache.act == ACT_IDX_DAT_RD)
    else $error("data index data read misdecoded");

  AST_D_IDX_DAT_WR: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_D_IDX_DAT_WR
    |=> result_o.cache.tgt == TGT_D && result_o.cache.act == ACT_IDX_DAT_WR)
    else $error("data index data write misdecoded");

  AST_S_IDX_WBINV: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_S_IDX_WBINV
    |=> result_o.cache.tgt == TGT_S && result_o.cache.act == ACT_IDX_WB_INV)
    else $error("secondary index writeback invalidate misdecoded");

  AST_S_IDX_TAG_RD: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_S_IDX_TAG_RD
    |=> result_o.cache.tgt == TGT_S && result_o.cache.act == ACT_IDX_TAG_RD)
    else $error("secondary index tag read misdecoded");

  AST_S_IDX_TAG_WR: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_S_IDX_TAG_WR
    |=> result_o.cache.tgt == TGT_S && result_o.cache.act == ACT_IDX_TAG_WR)
    else $error("secondary index tag write misdecoded");

  AST_S_HIT_WBINV: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_S_HIT_WBINV
    |=> result_o.cache.tgt == TGT_S && result_o.cache.act == ACT_HIT_WB_INV)
    else $error("secondary hit writeback invalidate misdecoded");

  AST_S_IDX_DAT_RD: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_S_IDX_DAT_RD
    |=> result_o.cache.tgt == TGT_S && result_o.cache.act == ACT_IDX_DAT_RD)
    else $error("secondary index data read misdecoded");

  AST_S_IDX_DAT_WR: assert property (
    accept && kind == K_CACHE && instr_i.rt == CO_S_IDX_DAT_WR
    |=> result_o.cache.tgt == TGT_S && result_o.cache.act == ACT_IDX_DAT_WR)
    else $error("secondary index data write misdecoded");

  // Main scenarios
  COV_BARRIER_WAIT: cover property (accept && sync_ok ##1 !mem_idle_i [*3] ##1 mem_idle_i);
  COV_CACHE_OK:     cover property (accept && kind == K_CACHE && c_act != ACT_NONE);
  COV_IRQ_RI:       cover property (accept && kind == K_IRQ_CTL);
  COV_BACK_TO_BACK: cover property (accept ##1 accept ##1 accept);
  COV_BAD_TYPE:     cover property (accept && sync_bad_type);

endmodule : isa_diff_decoder
`default_nettype wire

// [src/isa_diff_pkg.sv]
// Constants, encodings and carrier types for the implementation-difference decoder
package isa_diff_pkg;

  localparam int WAY_W = 2;

  // Major opcodes
  localparam logic [5:0] OPC_SPECIAL = 6'h00;
  localparam logic [5:0] OPC_COP0    = 6'h10;
  localparam logic [5:0] OPC_COP1X   = 6'h13;
  localparam logic [5:0] OPC_CACHE   = 6'h2f;
  localparam logic [5:0] OPC_PREFETCH_OP    = 6'h33;

  // Function and sub-field codes
  localparam logic [5:0] FN_SLL      = 6'h00;
  localparam logic [5:0] FN_SYNC     = 6'h0f;
  localparam logic [5:0] FN_PREFETCH_INDEXED_OP    = 6'h0f;
  localparam logic [5:0] FN_WAIT     = 6'h20;
  localparam logic [4:0] SA_SINGLE_ISSUE_NOOP    = 5'h01;
  localparam logic [4:0] SA_EHB      = 5'h03;
  localparam logic [4:0] RS_RDSHADOW = 5'h0a;
  localparam logic [4:0] RS_MFMC0    = 5'h0b;
  localparam logic [4:0] RS_WRSHADOW = 5'h0e;
  localparam logic [4:0] REG_ZERO    = 5'h00;
  localparam logic [4:0] SYNC_TYPE0  = 5'h00;
  localparam int         RS_CO_BIT   = 4;

  // Cache operation codes
  localparam logic [4:0] CO_I_IDX_INV    = 5'h00;
  localparam logic [4:0] CO_I_IDX_TAG_WR = 5'h08;
  localparam logic [4:0] CO_I_IDX_DAT_WR = 5'h1c;
  localparam logic [4:0] CO_D_IDX_WBINV  = 5'h01;
  localparam logic [4:0] CO_D_IDX_TAG_RD = 5'h05;
  localparam logic [4:0] CO_D_IDX_TAG_WR = 5'h09;
  localparam logic [4:0] CO_D_HIT_INV    = 5'h11;
  localparam logic [4:0] CO_D_HIT_WBINV  = 5'h15;
  localparam logic [4:0] CO_D_IDX_DAT_RD = 5'h19;
  localparam logic [4:0] CO_D_IDX_DAT_WR = 5'h1d;
  localparam logic [4:0] CO_S_IDX_WBINV  = 5'h03;
  localparam logic [4:0] CO_S_IDX_TAG_RD = 5'h07;
  localparam logic [4:0] CO_S_IDX_TAG_WR = 5'h0b;
  localparam logic [4:0] CO_S_HIT_WBINV  = 5'h13;
  localparam logic [4:0] CO_S_IDX_DAT_RD = 5'h1b;
  localparam logic [4:0] CO_S_IDX_DAT_WR = 5'h1f;
  localparam logic [2:0] CO_STORE_TOP    = 3'h7;

  typedef enum logic [2:0] {
    K_OTHER, K_NOP, K_WAIT, K_SHADOW_RD, K_SHADOW_WR, K_SYNC, K_CACHE, K_IRQ_CTL
  } instr_kind_e;

  typedef enum logic [1:0] {TGT_I, TGT_D, TGT_S, TGT_NONE} cache_tgt_e;

  typedef enum logic [3:0] {
    ACT_NONE, ACT_IDX_INV, ACT_IDX_WB_INV, ACT_IDX_TAG_RD, ACT_IDX_TAG_WR,
    ACT_HIT_INV, ACT_HIT_WB_INV, ACT_IDX_DAT_RD, ACT_IDX_DAT_WR
  } cache_act_e;

  typedef struct packed {
    logic [5:0] opc;
    logic [4:0] rs;
    logic [4:0] rt;
    logic [4:0] rd;
    logic [4:0] sa;
    logic [5:0] fn;
  } instr_s;

  typedef struct packed {
    logic             valid;
    cache_tgt_e       tgt;
    cache_act_e       act;
    logic [WAY_W-1:0] way;
  } cache_cmd_s;

  typedef struct packed {
    logic       valid;
    logic [4:0] src;
    logic [4:0] dst;
  } gpr_move_s;

  typedef struct packed {
    logic        valid;
    instr_kind_e kind;
    logic        exc_ri;
    logic        exc_cpu;
    cache_cmd_s  cache;
    gpr_move_s   move;
  } result_s;

endpackage : isa_diff_pkg

// [src/cache_op_decode.sv]
// Cache operation code decoder: target cache and action per op code
`timescale 1ns/10ps
`default_nettype none
module cache_op_decode
  import isa_diff_pkg::*;
(
  input  wire logic [4:0] cache_op_field_i,
  output cache_tgt_e      tgt_o,
  output cache_act_e      act_o
);

  // Full-code match; any code outside the table yields no action
  always_comb
  begin
    tgt_o = TGT_NONE;
    act_o = ACT_NONE;
    case (cache_op_field_i)
      CO_I_IDX_INV:    begin tgt_o = TGT_I; act_o = ACT_IDX_INV;    end
      CO_I_IDX_TAG_WR: begin tgt_o = TGT_I; act_o = ACT_IDX_TAG_WR; end
      CO_I_IDX_DAT_WR: begin tgt_o = TGT_I; act_o = ACT_IDX_DAT_WR; end
      CO_D_IDX_WBINV:  begin tgt_o = TGT_D; act_o = ACT_IDX_WB_INV; end
      CO_D_IDX_TAG_RD: begin tgt_o = TGT_D; act_o = ACT_IDX_TAG_RD; end
      CO_D_IDX_TAG_WR: begin tgt_o = TGT_D; act_o = ACT_IDX_TAG_WR; end
      CO_D_HIT_INV:    begin tgt_o = TGT_D; act_o = ACT_HIT_INV;    end
      CO_D_HIT_WBINV:  begin tgt_o = TGT_D; act_o = ACT_HIT_WB_INV; end
      CO_D_IDX_DAT_RD: begin tgt_o = TGT_D; act_o = ACT_IDX_DAT_RD; end
      CO_D_IDX_DAT_WR: begin tgt_o = TGT_D; act_o = ACT_IDX_DAT_WR; end
      CO_S_IDX_WBINV:  begin tgt_o = TGT_S; act_o = ACT_IDX_WB_INV; end
      CO_S_IDX_TAG_RD: begin tgt_o = TGT_S; act_o = ACT_IDX_TAG_RD; end
      CO_S_IDX_TAG_WR: begin tgt_o = TGT_S; act_o = ACT_IDX_TAG_WR; end
      CO_S_HIT_WBINV:  begin tgt_o = TGT_S; act_o = ACT_HIT_WB_INV; end
      CO_S_IDX_DAT_RD: begin tgt_o = TGT_S; act_o = ACT_IDX_DAT_RD; end
      CO_S_IDX_DAT_WR: begin tgt_o = TGT_S; act_o = ACT_IDX_DAT_WR; end
      default:         begin tgt_o = TGT_NONE; act_o = ACT_NONE; end
    endcase
  end

endmodule : cache_op_decode
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the implementation-difference decode stage
`timescale 1ns/10ps
`default_nettype none
module tb
  import isa_diff_pkg::*;
;
  logic                  clk_i;
  logic                  rst_b_i;
  logic                  instr_valid_i;
  instr_s                instr_i;
  logic                  sys_coproc_usable_bit_i;
  logic [WAY_W-1:0]      vaddr_lo_i;
  logic                  mem_idle_i;
  logic                  instr_ready_o;
  result_s               result_o;
  logic                  mem_hold_o;
  int                    n_fail;
  int                    cmp_count;

  // Supported cache codes with expected target and action
  logic [4:0]  co_tab[16] = '{5'h00, 5'h08, 5'h1c, 5'h01, 5'h05, 5'h09, 5'h11, 5'h15,
                              5'h19, 5'h1d, 5'h03, 5'h07, 5'h0b, 5'h13, 5'h1b, 5'h1f};
  cache_tgt_e  tg_tab[16] = '{TGT_I, TGT_I, TGT_I, TGT_D, TGT_D, TGT_D, TGT_D, TGT_D,
                              TGT_D, TGT_D, TGT_S, TGT_S, TGT_S, TGT_S, TGT_S, TGT_S};
  cache_act_e  ac_tab[16] = '{ACT_IDX_INV, ACT_IDX_TAG_WR, ACT_IDX_DAT_WR, ACT_IDX_WB_INV,
                              ACT_IDX_TAG_RD, ACT_IDX_TAG_WR, ACT_HIT_INV, ACT_HIT_WB_INV,
                              ACT_IDX_DAT_RD, ACT_IDX_DAT_WR, ACT_IDX_WB_INV, ACT_IDX_TAG_RD,
                              ACT_IDX_TAG_WR, ACT_HIT_WB_INV, ACT_IDX_DAT_RD, ACT_IDX_DAT_WR};

  isa_diff_decoder DUT (
    .clk_i                   (clk_i),
    .rst_b_i                 (rst_b_i),
    .instr_valid_i           (instr_valid_i),
    .instr_i                 (instr_i),
    .sys_coproc_usable_bit_i (sys_coproc_usable_bit_i),
    .vaddr_lo_i              (vaddr_lo_i),
    .mem_idle_i              (mem_idle_i),
    .instr_ready_o           (instr_ready_o),
    .result_o                (result_o),
    .mem_hold_o              (mem_hold_o)
  );

  // 40 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("BAD t=%0t %s", $time, msg);
    end
  endtask : chk

  function automatic instr_s mk(input logic [5:0] opc, input logic [4:0] rs, input logic [4:0] rt,
                                input logic [4:0] rd, input logic [4:0] sa, input logic [5:0] fn);
    mk = '{opc: opc, rs: rs, rt: rt, rd: rd, sa: sa, fn: fn};
  endfunction : mk

  // One request, held for one clock edge without waiting on instr_ready_o; returns just after it
  task automatic take(input instr_s w, input logic cu, input logic [WAY_W-1:0] vlo);
    @(posedge clk_i);
    instr_valid_i           <= 1'b1;
    instr_i                 <= w;
    sys_coproc_usable_bit_i <= cu;
    vaddr_lo_i              <= vlo;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask : take

  // Plain retire: one-cycle result, no exception, no side action
  task automatic chk_plain(input instr_kind_e k, input string msg);
    chk(result_o.valid === 1'b1 && result_o.kind === k, msg);
    chk(result_o.exc_ri === 1'b0 && result_o.exc_cpu === 1'b0, msg);
    chk(result_o.cache.valid === 1'b0 && mem_hold_o === 1'b0, msg);
  endtask : chk_plain

  task automatic t_nops();
    take(mk(OPC_PREFETCH_OP, 5'h01, 5'h02, 5'h03, 5'h04, 6'h05), 1'b1, 2'h0);
    chk_plain(K_NOP, "prefetch not a no-op");
    take(mk(OPC_COP1X, 5'h01, 5'h02, 5'h00, 5'h00, FN_PREFETCH_INDEXED_OP), 1'b1, 2'h0);
    chk_plain(K_NOP, "indexed prefetch not a no-op");
    take(mk(OPC_SPECIAL, 5'h00, 5'h00, 5'h00, SA_SINGLE_ISSUE_NOOP, FN_SLL), 1'b1, 2'h0);
    chk_plain(K_NOP, "single-issue no-op wrong");
    take(mk(OPC_SPECIAL, 5'h00, 5'h00, 5'h00, SA_EHB, FN_SLL), 1'b1, 2'h0);
    chk_plain(K_NOP, "hazard barrier wrong");
    // An ordinary load retires with no side action
    take(mk(6'h23, 5'h01, 5'h02, 5'h00, 5'h00, 6'h00), 1'b1, 2'h0);
    chk_plain(K_OTHER, "ordinary instruction wrong");
  endtask : t_nops

  task automatic t_wait();
    take(mk(OPC_COP0, 5'h10, 5'h00, 5'h00, 5'h00, FN_WAIT), 1'b1, 2'h0);
    chk_plain(K_WAIT, "wait retire wrong");
    chk(instr_ready_o === 1'b1, "wait stalled the stage");
  endtask : t_wait

  task automatic t_shadow();
    take(mk(OPC_COP0, RS_RDSHADOW, 5'h05, 5'h09, 5'h00, 6'h00), 1'b1, 2'h0);
    chk_plain(K_SHADOW_RD, "read shadow kind");
    chk(result_o.move === gpr_move_s'{valid: 1'b1, src: 5'h05, dst: 5'h09},
        "read shadow move");
    take(mk(OPC_COP0, RS_WRSHADOW, 5'h1e, 5'h01, 5'h00, 6'h00), 1'b1, 2'h0);
    chk_plain(K_SHADOW_WR, "write shadow kind");
    chk(result_o.move === gpr_move_s'{valid: 1'b1, src: 5'h1e, dst: 5'h01},
        "write shadow move");
  endtask : t_shadow

  task automatic t_barrier();
    int n;
    // Good barrier held off by outstanding memory traffic
    mem_idle_i <= 1'b0;
    take(mk(OPC_SPECIAL, 5'h00, 5'h00, 5'h00, SYNC_TYPE0, FN_SYNC), 1'b1, 2'h0);
    repeat (4)
    begin
      chk(mem_hold_o === 1'b1 && instr_ready_o === 1'b0, "barrier not holding");
      chk(result_o.valid === 1'b0, "barrier retired early");
      @(posedge clk_i);
      #1;
    end
    mem_idle_i <= 1'b1;
    n = 0;
    while (result_o.valid !== 1'b1 && n < 10)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk_plain(K_SYNC, "good barrier retire");
    chk(instr_ready_o === 1'b1, "barrier left stage blocked");
    // Drained memory still costs the barrier one holding cycle
    take(mk(OPC_SPECIAL, 5'h00, 5'h00, 5'h00, SYNC_TYPE0, FN_SYNC), 1'b1, 2'h0);
    chk(mem_hold_o === 1'b1 && result_o.valid === 1'b0, "drained barrier skipped hold");
    @(posedge clk_i);
    #1;
    chk_plain(K_SYNC, "drained barrier retire");
    chk(instr_ready_o === 1'b1, "drained barrier left stage blocked");
    // Non-zero types are reserved; type check wins over usability
    for (int t = 1; t < 32; t += 10)
    begin
      take(mk(OPC_SPECIAL, 5'h00, 5'h00, 5'h00, t[4:0], FN_SYNC), t[1], 2'h0);
      chk(result_o.valid === 1'b1 && result_o.exc_ri === 1'b1, "bad type not refused");
      chk(result_o.exc_cpu === 1'b0 && mem_hold_o === 1'b0, "bad type side effect");
    end
    take(mk(OPC_SPECIAL, 5'h00, 5'h00, 5'h00, SYNC_TYPE0, FN_SYNC), 1'b0, 2'h0);
    chk(result_o.valid === 1'b1 && result_o.exc_cpu === 1'b1, "user barrier allowed");
    chk(result_o.exc_ri === 1'b0 && mem_hold_o === 1'b0, "user barrier side effect");
  endtask : t_barrier

  task automatic t_cache();
    logic [1:0] w;
    logic [4:0] bad_tab[3] = '{5'h1e, 5'h02, 5'h14};
    for (int i = 0; i < 16; i++)
    begin
      w = i[1:0] ^ 2'h2;
      take(mk(OPC_CACHE, 5'h04, co_tab[i], 5'h00, 5'h00, 6'h00), 1'b1, w);
      chk(result_o.valid === 1'b1 && result_o.kind === K_CACHE, "cache kind");
      chk(result_o.cache.valid === 1'b1 && result_o.cache.tgt === tg_tab[i], "cache target");
      chk(result_o.cache.act === ac_tab[i], "cache action");
      if (ac_tab[i] != ACT_HIT_INV && ac_tab[i] != ACT_HIT_WB_INV)
        chk(result_o.cache.way === w, "index way select");
      if (co_tab[i][4:2] == CO_STORE_TOP)
        chk(result_o.cache.act === ACT_IDX_DAT_WR, "store-data top codes");
    end
    // Unlisted codes, including the two tertiary-looking ones, do nothing
    for (int k = 0; k < 3; k++)
    begin
      take(mk(OPC_CACHE, 5'h04, bad_tab[k], 5'h00, 5'h00, 6'h00), 1'b1, 2'h1);
      chk(result_o.valid === 1'b1 && result_o.cache.valid === 1'b0, "unlisted cache op");
    end
  endtask : t_cache

  task automatic t_irq();
    for (int s = 0; s < 2; s++)
    begin
      take(mk(OPC_COP0, RS_MFMC0, 5'h03, 5'h0c, 5'h00, {s[0], 5'h00}), 1'b1, 2'h0);
      chk(result_o.valid === 1'b1 && result_o.exc_ri === 1'b1, "irq ctl not refused");
      chk(result_o.kind === K_IRQ_CTL && result_o.move.valid === 1'b0, "irq ctl executed");
    end
  endtask : t_irq

  // Watchdog, far beyond the fewer than 100 cycles the tests need
  initial
  begin
    #(25 * 5000);
    n_fail++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    n_fail                  = 0;
    cmp_count               = 0;
    rst_b_i                 = 1'b0;
    instr_valid_i           = 1'b0;
    instr_i                 = '0;
    sys_coproc_usable_bit_i = 1'b1;
    vaddr_lo_i              = 2'h0;
    mem_idle_i              = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk(instr_ready_o === 1'b0 && mem_hold_o === 1'b0, "reset outputs");
    chk(result_o.valid === 1'b0 && result_o.cache.tgt === TGT_NONE, "reset result");
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_nops();
    t_wait();
    t_shadow();
    t_barrier();
    t_cache();
    t_irq();
    finish_test();
  end
endmodule : tb
`default_nettype wire
